// ### dpsr_top.sv
// Dual-port synchronous static RAM, two independent ports on one clock.
// Assumes masters are logic on mclk; each port clock is a strobe input.
`timescale 1ns/10ps
`include "dpsr_cfg.svh"

module dpsr_top #(
  parameter int ADDR_W = `DPSR_ADDR_W,
  parameter int DATA_W = `DPSR_DATA_W,
  parameter int LANE_W = `DPSR_LANE_W,
  parameter int LANES  = `DPSR_LANES
) (
  // Clock, reset, freeze
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Left port control
  input  wire logic              l_clk_strobe,
  input  wire logic              l_port_select_lo_n,
  input  wire logic              l_port_select_hi,
  input  wire logic              l_read_write,
  input  wire logic              l_out_enable_n,
  input  wire logic              l_low_lane_enable_n,
  input  wire logic              l_high_lane_enable_n,
  input  wire logic              l_output_stage_select,
  input  wire logic              l_addr_load_strobe_n,
  input  wire logic              l_burst_advance_n,
  input  wire logic              l_burst_clear_n,
  input  wire logic [ADDR_W-1:0] l_addr,
  // Left port data pins
  input  wire logic [DATA_W-1:0] l_dq_i,
  output logic      [DATA_W-1:0] l_dq_o,
  output logic      [LANES-1:0]  l_dq_oe,
  // Right port control
  input  wire logic              r_clk_strobe,
  input  wire logic              r_port_select_lo_n,
  input  wire logic              r_port_select_hi,
  input  wire logic              r_read_write,
  input  wire logic              r_out_enable_n,
  input  wire logic              r_low_lane_enable_n,
  input  wire logic              r_high_lane_enable_n,
  input  wire logic              r_output_stage_select,
  input  wire logic              r_addr_load_strobe_n,
  input  wire logic              r_burst_advance_n,
  input  wire logic              r_burst_clear_n,
  input  wire logic [ADDR_W-1:0] r_addr,
  // Right port data pins
  input  wire logic [DATA_W-1:0] r_dq_i,
  output logic      [DATA_W-1:0] r_dq_o,
  output logic      [LANES-1:0]  r_dq_oe
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  typedef struct packed {
    dpsr_pkg::dpsr_port_regs_t left;
    dpsr_pkg::dpsr_port_regs_t right;
  } dpsr_top_state_t;

  localparam int DEPTH = 1 << ADDR_W;

  dpsr_top_state_t     st_ff;
  dpsr_top_state_t     nxt_st;
  logic [DATA_W-1:0]   mem_q [DEPTH];
  logic                l_tick;
  logic                r_tick;
  logic [ADDR_W-1:0]   l_addr_q;
  logic [ADDR_W-1:0]   r_addr_q;
  logic [DATA_W-1:0]   l_rdata;
  logic [DATA_W-1:0]   r_rdata;
  logic                l_rd_valid;
  logic                r_rd_valid;
  logic [LANES-1:0]    l_lane_en;
  logic [LANES-1:0]    r_lane_en;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Both selects must agree for the port to be active
  function automatic logic sel_decode(input logic lo_n, input logic hi);
    return ~lo_n & hi;
  endfunction

  // Capture one port's pins at its own clock edge
  function automatic dpsr_pkg::dpsr_port_regs_t port_capture(
    input dpsr_pkg::dpsr_port_regs_t cur,
    input logic                      tick,
    input logic                      lo_n,
    input logic                      hi,
    input logic                      rw,
    input logic                      oe_n,
    input logic                      lb_n,
    input logic                      ub_n,
    input logic                      stage,
    input logic [DATA_W-1:0]         din);
    dpsr_pkg::dpsr_port_regs_t r;
    r       = cur;
    r.wpend = 1'b0;
    if (tick) begin
      r.sel    = sel_decode(lo_n, hi);
      r.wr     = ~rw;
      r.lane_n = {ub_n, lb_n};
      r.oe_n   = oe_n;
      r.pipe   = stage;
      r.wdata  = din;
      r.wpend  = sel_decode(lo_n, hi) & ~rw;
    end
    return r;
  endfunction

  // Lanes that may drive on a read
  function automatic logic [LANES-1:0] lane_gate(
    input dpsr_pkg::dpsr_port_regs_t p);
    return ~p.lane_n & {LANES{~p.oe_n}};
  endfunction

  // ****************************************************************
  // Port strobes and input registers
  // ****************************************************************

  // Strobed port clocks become qualified ticks of mclk
  assign l_tick = ce & l_clk_strobe;
  assign r_tick = ce & r_clk_strobe;

  // Next state of both ports' input registers
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.left  = port_capture(st_ff.left, l_tick,
                                  l_port_select_lo_n, l_port_select_hi,
                                  l_read_write, l_out_enable_n,
                                  l_low_lane_enable_n,
                                  l_high_lane_enable_n,
                                  l_output_stage_select, l_dq_i);
      nxt_st.right = port_capture(st_ff.right, r_tick,
                                  r_port_select_lo_n, r_port_select_hi,
                                  r_read_write, r_out_enable_n,
                                  r_low_lane_enable_n,
                                  r_high_lane_enable_n,
                                  r_output_stage_select, r_dq_i);
    end
  end

  // Reset leaves both ports deselected
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Burst counters, one per port
  // ****************************************************************

  // Counters act in either output mode alike
  dpsr_burst #(
    .ADDR_W   (ADDR_W)
  ) u_l_burst (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick     (l_tick),
    .load_n   (l_addr_load_strobe_n),
    .adv_n    (l_burst_advance_n),
    .clr_n    (l_burst_clear_n),
    .load_val (l_addr),
    .addr     (l_addr_q)
  );

  dpsr_burst #(
    .ADDR_W   (ADDR_W)
  ) u_r_burst (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick     (r_tick),
    .load_n   (r_addr_load_strobe_n),
    .adv_n    (r_burst_advance_n),
    .clr_n    (r_burst_clear_n),
    .load_val (r_addr),
    .addr     (r_addr_q)
  );

  // ****************************************************************
  // Array
  // ****************************************************************

  // Self-timed write one mclk after capture; no arbitration between
  // ports, so a same-word clash keeps the right port's lane
  always_ff @(posedge mclk) begin
    if (ce) begin
      for (int i = 0; i < LANES; i++) begin
        if (st_ff.left.wpend && !st_ff.left.lane_n[i]) begin
          mem_q[l_addr_q][i*LANE_W +: LANE_W] <=
            st_ff.left.wdata[i*LANE_W +: LANE_W];
        end
        if (st_ff.right.wpend && !st_ff.right.lane_n[i]) begin
          mem_q[r_addr_q][i*LANE_W +: LANE_W] <=
            st_ff.right.wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Reads see the array before any write at the same edge
  assign l_rdata    = mem_q[l_addr_q];
  assign r_rdata    = mem_q[r_addr_q];
  assign l_rd_valid = st_ff.left.sel & ~st_ff.left.wr;
  assign r_rd_valid = st_ff.right.sel & ~st_ff.right.wr;
  assign l_lane_en  = lane_gate(st_ff.left);
  assign r_lane_en  = lane_gate(st_ff.right);

  // ****************************************************************
  // Output stages
  // ****************************************************************

  // Mode taken from the registered stage select
  dpsr_lane_out #(
    .DATA_W   (DATA_W),
    .LANES    (LANES)
  ) u_l_out (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick     (l_tick),
    .pipe     (st_ff.left.pipe),
    .rd_valid (l_rd_valid),
    .lane_en  (l_lane_en),
    .rdata    (l_rdata),
    .dq_o     (l_dq_o),
    .dq_oe    (l_dq_oe)
  );

  dpsr_lane_out #(
    .DATA_W   (DATA_W),
    .LANES    (LANES)
  ) u_r_out (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick     (r_tick),
    .pipe     (st_ff.right.pipe),
    .rd_valid (r_rd_valid),
    .lane_en  (r_lane_en),
    .rdata    (r_rdata),
    .dq_o     (r_dq_o),
    .dq_oe    (r_dq_oe)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking dpsr_cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_select_decode: assert property (
    l_tick |=> st_ff.left.sel ==
               $past(!l_port_select_lo_n && l_port_select_hi))
    else $error("left select decoded wrongly");

  a_desel_no_write: assert property (
    r_tick && (r_port_select_lo_n || !r_port_select_hi)
      |=> !st_ff.right.wpend)
    else $error("deselected right port wrote");

  a_write_lands: assert property (
    ce && st_ff.left.wpend && !st_ff.left.lane_n[0]
      && !(st_ff.right.wpend && r_addr_q == l_addr_q)
      |=> mem_q[$past(l_addr_q)][LANE_W-1:0] ==
          $past(st_ff.left.wdata[LANE_W-1:0]))
    else $error("left low lane write lost");

  a_lane_masked: assert property (
    ce && st_ff.right.wpend && st_ff.right.lane_n[1]
      && !(st_ff.left.wpend && l_addr_q == r_addr_q)
      |=> mem_q[$past(r_addr_q)][DATA_W-1:LANE_W] ==
          $past(r_rdata[DATA_W-1:LANE_W]))
    else $error("right high lane written while disabled");

  a_flow_one_tick: assert property (
    l_tick && !l_port_select_lo_n && l_port_select_hi && l_read_write
      && !l_out_enable_n && !l_low_lane_enable_n
      && l_output_stage_select == `DPSR_STAGE_FLOW ##1 l_tick
      |=> l_dq_oe[0] &&
          l_dq_o[LANE_W-1:0] == $past(l_rdata[LANE_W-1:0]))
    else $error("flow-through read not on pins after one tick");

  a_pipe_two_ticks: assert property (
    r_tick && !r_port_select_lo_n && r_port_select_hi && r_read_write
      && !r_out_enable_n && !r_high_lane_enable_n
      && r_output_stage_select == `DPSR_STAGE_PIPE
      ##1 (r_tick && r_output_stage_select == `DPSR_STAGE_PIPE)
      ##1 r_tick
      |=> r_dq_oe[1])
    else $error("pipelined read not on pins after two ticks");

  a_oe_blocks: assert property (
    l_tick && st_ff.left.oe_n && !st_ff.left.pipe |=> l_dq_oe == '0)
    else $error("left lanes driven with output enable high");

  a_freeze_holds: assert property (
    !ce |=> $stable(st_ff) && $stable(l_dq_o) && $stable(r_dq_oe))
    else $error("state moved while clock enable low");

  c_left_burst: cover property (
    (l_tick && l_burst_clear_n && l_addr_load_strobe_n
      && !l_burst_advance_n) [*3]);
  c_both_write: cover property (st_ff.left.wpend && st_ff.right.wpend);
  c_pipe_read: cover property (st_ff.left.pipe && l_dq_oe != '0);
  c_flow_read: cover property (!st_ff.right.pipe && r_dq_oe != '0);
  // Partial-lane write, the case the lane mask check needs
  c_lane_write: cover property (
    st_ff.right.wpend && st_ff.right.lane_n != 2'h0);

endmodule

// ### dpsr_cfg.svh
// Constants for the dual-port synchronous static RAM block.
// Assumes it is included by bare name; definitions only.
`ifndef DPSR_CFG_SVH
`define DPSR_CFG_SVH

// ****************************************************************
// Array shape
// ****************************************************************
`define DPSR_DATA_W     18
`define DPSR_LANE_W     9
`define DPSR_LANES      2
`define DPSR_ADDR_W_4K  12
`define DPSR_ADDR_W_8K  13
`define DPSR_ADDR_W     `DPSR_ADDR_W_8K

// ****************************************************************
// Output stage select levels
// ****************************************************************
`define DPSR_STAGE_FLOW 1'b0
`define DPSR_STAGE_PIPE 1'b1

`endif

// ### dpsr_pkg.sv
// Types shared by the dual-port RAM modules.
// Assumes dpsr_cfg.svh is reachable on the include path.
`include "dpsr_cfg.svh"

package dpsr_pkg;

  // Burst counter action, Gray along hold-load-advance-clear
  typedef enum logic [1:0] {
    DPSR_HOLD = 2'h0,
    DPSR_LOAD = 2'h1,
    DPSR_ADV  = 2'h3,
    DPSR_CLR  = 2'h2
  } dpsr_ctr_op_t;

  // Input registers of one port
  typedef struct packed {
    logic                     sel;
    logic                     wpend;
    logic                     wr;
    logic [`DPSR_LANES-1:0]   lane_n;
    logic                     oe_n;
    logic                     pipe;
    logic [`DPSR_DATA_W-1:0]  wdata;
  } dpsr_port_regs_t;

endpackage

// ### dpsr_burst.sv
// Burst address counter that doubles as a port's address register.
// Assumes tick is the port clock strobe already gated by clock enable.
`timescale 1ns/10ps
`include "dpsr_cfg.svh"

module dpsr_burst #(
  parameter int ADDR_W = `DPSR_ADDR_W
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              tick,
  // Counter controls
  input  wire logic              load_n,
  input  wire logic              adv_n,
  input  wire logic              clr_n,
  input  wire logic [ADDR_W-1:0] load_val,
  // Access address
  output logic      [ADDR_W-1:0] addr
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } dpsr_ctr_state_t;

  dpsr_ctr_state_t st_ff;
  dpsr_ctr_state_t nxt_st;
  dpsr_pkg::dpsr_ctr_op_t op;

  // Clear beats load, load beats advance
  function automatic dpsr_pkg::dpsr_ctr_op_t ctr_decode(
    input logic ld_n, input logic ad_n, input logic cl_n);
    if (!cl_n) begin
      return dpsr_pkg::DPSR_CLR;
    end else if (!ld_n) begin
      return dpsr_pkg::DPSR_LOAD;
    end else if (!ad_n) begin
      return dpsr_pkg::DPSR_ADV;
    end
    return dpsr_pkg::DPSR_HOLD;
  endfunction

  // Next counter value
  always_comb begin
    op     = ctr_decode(load_n, adv_n, clr_n);
    nxt_st = st_ff;
    if (tick) begin
      case (op)
        dpsr_pkg::DPSR_CLR:  nxt_st.addr = '0;
        dpsr_pkg::DPSR_LOAD: nxt_st.addr = load_val;
        // Advance ignores the pins and wraps at the top
        dpsr_pkg::DPSR_ADV:  nxt_st.addr = ADDR_W'(st_ff.addr + 1'b1);
        default:             nxt_st.addr = st_ff.addr;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign addr = st_ff.addr;

  a_clear_wins: assert property (@(posedge mclk) disable iff (!nrst)
    tick && !clr_n |=> addr == '0)
    else $error("counter not cleared");
  a_advance_step: assert property (@(posedge mclk) disable iff (!nrst)
    tick && clr_n && load_n && !adv_n
      |=> addr == ADDR_W'($past(addr) + 1'b1))
    else $error("counter did not step by one");
  a_load_takes: assert property (@(posedge mclk) disable iff (!nrst)
    tick && clr_n && !load_n |=> addr == $past(load_val))
    else $error("counter did not load");

endmodule

// ### dpsr_lane_out.sv
// Read output stage of one port: optional pipeline register, lane drive.
// Assumes tick is the port clock strobe already gated by clock enable.
`timescale 1ns/10ps
`include "dpsr_cfg.svh"

module dpsr_lane_out #(
  parameter int DATA_W = `DPSR_DATA_W,
  parameter int LANES  = `DPSR_LANES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              tick,
  // Read request
  input  wire logic              pipe,
  input  wire logic              rd_valid,
  input  wire logic [LANES-1:0]  lane_en,
  input  wire logic [DATA_W-1:0] rdata,
  // Data pins
  output logic      [DATA_W-1:0] dq_o,
  output logic      [LANES-1:0]  dq_oe
);

  typedef struct packed {
    logic [DATA_W-1:0] pdata;
    logic [LANES-1:0]  poe;
    logic [DATA_W-1:0] odata;
    logic [LANES-1:0]  ooe;
  } dpsr_out_state_t;

  dpsr_out_state_t st_ff;
  dpsr_out_state_t nxt_st;
  logic [LANES-1:0] now_oe;

  // Pipe stage always loads; mux picks array or pipe for the pins
  always_comb begin
    now_oe = rd_valid ? lane_en : '0;
    nxt_st = st_ff;
    if (tick) begin
      nxt_st.pdata = rdata;
      nxt_st.poe   = now_oe;
      if (pipe == `DPSR_STAGE_PIPE) begin
        nxt_st.odata = st_ff.pdata;
        nxt_st.ooe   = st_ff.poe;
      end else begin
        nxt_st.odata = rdata;
        nxt_st.ooe   = now_oe;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dq_o  = st_ff.odata;
  assign dq_oe = st_ff.ooe;

  a_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    tick && !rd_valid && !pipe |=> dq_oe == '0)
    else $error("lanes driven without a read");

endmodule

// ### dpsr_master.sv
// Bus master model for one port of the dual-port RAM.
// Assumes a free-running mclk; pins change just after falling edges.
`timescale 1ns/10ps

module dpsr_master #(
  parameter int AW = 13
) (
  // Clock
  input  wire logic          mclk,
  // Port pins
  output logic               strb,
  output logic               lo_n,
  output logic               hi,
  output logic               rw,
  output logic               oe_n,
  output logic [1:0]         lane_n,
  output logic               stage,
  output logic               ld_n,
  output logic               adv_n,
  output logic               clr_n,
  output logic [AW-1:0]      addr,
  output logic [17:0]        dq,
  // Read-back pins
  input  wire logic [17:0]   dq_o,
  input  wire logic [1:0]    dq_oe
);
  // ****************************************
  // Cycle driver
  // ****************************************
  logic [17:0] q;
  logic [1:0]  q_oe;
  logic        pipe_mode;
  logic        gate;

  // Deselected with the counter idle from time zero
  initial begin
    {strb, lo_n, hi, rw, oe_n, lane_n, stage, ld_n, adv_n, clr_n} = 11'h6f7;
    addr = '0;
    dq = '0;
    pipe_mode = 1'b0;
    gate = 1'b1;
  end

  // One port cycle; q holds the pins just after this cycle's edge
  task automatic cyc(input logic [1:0] sel, input logic w, input logic o,
                     input logic [1:0] ln, input logic [2:0] ctl,
                     input logic [AW-1:0] a, input logic [17:0] d);
    @(negedge mclk);
    strb = gate;
    {lo_n, hi} = sel;
    rw = w;
    oe_n = o;
    lane_n = ln;
    stage = pipe_mode;  // Low flow-through, high pipelined
    {ld_n, adv_n, clr_n} = ctl;
    addr = a;
    // Released bus flips each cycle so no stale word can pass
    dq = w ? ~dq : d;
    @(posedge mclk);
    #1;
    q = dq_o;
    q_oe = dq_oe;
  endtask

  // Single accesses qualify the address with the load strobe
  task automatic rd(input logic [AW-1:0] a, input logic [1:0] ln);
    cyc(2'h1, 1'b1, 1'b0, ln, 3'h3, a, 18'h0);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [17:0] d);
    cyc(2'h1, 1'b0, 1'b0, 2'h0, 3'h3, a, d);
  endtask
  // Deselect; still strobes the port, so a pipelined read can finish on it
  task automatic nop();
    cyc(2'h2, 1'b1, 1'b1, 2'h3, 3'h7, addr, 18'h0);
  endtask
endmodule

// ### test_dpsr_top.sv
// Self-checking bench for the dual-port RAM top, one master per port.
// Assumes the 13-bit address default and port clocks as mclk strobes.
`timescale 1ns/10ps

module test_dpsr_top;
  // ****************************************
  // Pins and constants
  // ****************************************
  localparam int            AW   = 13;
  localparam logic [AW-1:0] TOP  = '1;
  localparam logic [AW-1:0] A1   = 13'h0123;
  localparam logic [AW-1:0] A2   = 13'h1456;
  localparam logic [17:0]   D1   = 18'h2a5a5;
  localparam logic [17:0]   D2   = 18'h1c3c3;
  localparam logic [17:0]   DB   = 18'h10000;
  localparam logic [17:0]   MEM1 = D1 & 18'h3fe00;
  logic          mclk, nrst, ce;
  logic          l_clk_strobe, l_port_select_lo_n, l_port_select_hi;
  logic          l_read_write, l_out_enable_n, l_output_stage_select;
  wire           l_low_lane_enable_n, l_high_lane_enable_n;
  logic          l_addr_load_strobe_n, l_burst_advance_n, l_burst_clear_n;
  logic          r_clk_strobe, r_port_select_lo_n, r_port_select_hi;
  logic          r_read_write, r_out_enable_n, r_output_stage_select;
  wire           r_low_lane_enable_n, r_high_lane_enable_n;
  logic          r_addr_load_strobe_n, r_burst_advance_n, r_burst_clear_n;
  logic [AW-1:0] l_addr, r_addr;
  logic [17:0]   l_dq_i, l_dq_o, r_dq_i, r_dq_o;
  logic [1:0]    l_dq_oe, r_dq_oe;
  int            n_fail, samples_checked;

  dpsr_top dut_u (.*);
  dpsr_master #(.AW(AW)) lm (.mclk(mclk), .strb(l_clk_strobe),
    .lo_n(l_port_select_lo_n), .hi(l_port_select_hi), .rw(l_read_write),
    .oe_n(l_out_enable_n),
    .lane_n({l_high_lane_enable_n, l_low_lane_enable_n}),
    .stage(l_output_stage_select), .ld_n(l_addr_load_strobe_n),
    .adv_n(l_burst_advance_n), .clr_n(l_burst_clear_n), .addr(l_addr),
    .dq(l_dq_i), .dq_o(l_dq_o), .dq_oe(l_dq_oe));
  dpsr_master #(.AW(AW)) rm (.mclk(mclk), .strb(r_clk_strobe),
    .lo_n(r_port_select_lo_n), .hi(r_port_select_hi), .rw(r_read_write),
    .oe_n(r_out_enable_n),
    .lane_n({r_high_lane_enable_n, r_low_lane_enable_n}),
    .stage(r_output_stage_select), .ld_n(r_addr_load_strobe_n),
    .adv_n(r_burst_advance_n), .clr_n(r_burst_clear_n), .addr(r_addr),
    .dq(r_dq_i), .dq_o(r_dq_o), .dq_oe(r_dq_oe));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************
  // Checking and verdict
  // ****************************************
  task automatic chk(input string nm, input logic [17:0] seen,
                     input logic [17:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task end_of_test();
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Both ports write, then read each other's word in the same cycles
  task automatic t_basic();
    fork  // Never the same word on both ports at once
      lm.wr(A1, D1);
      rm.wr(A2, D2);
    join
    fork
      lm.rd(A2, 2'h0);
      rm.rd(A1, 2'h0);
    join
    fork
      lm.nop();
      rm.nop();
    join
    chk("left rdata", lm.q, D2);
    chk("right rdata", rm.q, D1);
    chk("left oe", {16'h0, lm.q_oe}, 18'h3);
  endtask

  // Low lane overwritten alone, then lanes and output enable read back
  task automatic t_lanes();
    lm.cyc(2'h1, 1'b0, 1'b0, 2'h2, 3'h3, A1, 18'h0);
    lm.rd(A1, 2'h1);
    lm.rd(A1, 2'h2);
    chk("high lane", lm.q & 18'h3fe00, MEM1);
    chk("high oe", {16'h0, lm.q_oe}, 18'h2);
    lm.cyc(2'h1, 1'b1, 1'b1, 2'h0, 3'h3, A1, 18'h0);
    chk("low lane", lm.q & 18'h001ff, 18'h0);
    chk("low oe", {16'h0, lm.q_oe}, 18'h1);
    lm.nop();
    chk("oe off", {16'h0, lm.q_oe}, 18'h0);
  endtask

  // Right port pipelined: data one tick later than flow-through
  task automatic t_pipe();
    rm.pipe_mode = 1'b1;
    rm.nop();
    rm.rd(A2, 2'h0);
    rm.nop();
    chk("pipe early", {16'h0, rm.q_oe}, 18'h0);
    rm.nop();
    chk("pipe data", rm.q, D2);
    chk("pipe oe", {16'h0, rm.q_oe}, 18'h3);
    rm.pipe_mode = 1'b0;
    rm.nop();
    rm.nop();
  endtask

  // Burst write across the top of the array, then clear, load and advance
  task automatic t_burst();
    logic [2:0]  ctl [6] = '{3'h0, 3'h5, 3'h1, 3'h5, 3'h7, 3'h7};
    logic [17:0] want [5] = '{DB + 18'h2, DB + 18'h3, DB, DB + 18'h1,
                              DB + 18'h1};
    lm.cyc(2'h1, 1'b0, 1'b0, 2'h0, 3'h3, TOP - 13'h1, DB);
    // Address pins left on junk while advancing
    for (int i = 1; i < 4; i++)
      lm.cyc(2'h1, 1'b0, 1'b0, 2'h0, 3'h5, 13'h0aaa, DB + 18'(i));
    for (int i = 0; i < 6; i++) begin
      lm.cyc(2'h1, 1'b1, 1'b0, 2'h0, ctl[i],
             (i == 2) ? TOP - 13'h1 : 13'h0aaa, 18'h0);
      if (i > 0) chk("burst", lm.q, want[i-1]);
    end
    // Right port: low lane only, then a pipelined burst read back
    rm.cyc(2'h1, 1'b0, 1'b0, 2'h2, 3'h3, TOP - 13'h1, 18'h3ffff);
    rm.pipe_mode = 1'b1;
    rm.nop();
    rm.cyc(2'h1, 1'b1, 1'b0, 2'h0, 3'h3, TOP - 13'h1, 18'h0);
    rm.cyc(2'h1, 1'b1, 1'b0, 2'h0, 3'h5, 13'h0aaa, 18'h0);
    rm.cyc(2'h1, 1'b1, 1'b0, 2'h0, 3'h5, 13'h0aaa, 18'h0);
    chk("pipe burst 0", rm.q, DB | 18'h001ff);
    rm.nop();
    chk("pipe burst 1", rm.q, DB + 18'h1);
    rm.nop();
    chk("pipe burst 2", rm.q, DB + 18'h2);
  endtask

  // Every deselecting select pair refuses writes and leaves pins off
  task automatic t_desel();
    logic [1:0] sel [3] = '{2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++) begin
      lm.cyc(sel[i], 1'b0, 1'b0, 2'h0, 3'h3, A1, 18'h3ffff);
      lm.cyc(sel[i], 1'b1, 1'b0, 2'h0, 3'h3, A1, 18'h0);
      lm.rd(A1, 2'h0);
      chk("desel oe", {16'h0, lm.q_oe}, 18'h0);
      lm.nop();
      chk("desel keep", lm.q, MEM1);
    end
  endtask

  // Missing strobes and a low clock enable both hold the answer back
  task automatic t_gate();
    lm.rd(A2, 2'h0);
    lm.rd(A1, 2'h0);
    lm.gate = 1'b0;
    lm.nop();
    chk("gated hold", lm.q, D2);
    lm.gate = 1'b1;
    @(negedge mclk) ce = 1'b0;
    lm.nop();
    chk("frozen", lm.q, D2);
    @(negedge mclk) ce = 1'b1;
    @(posedge mclk);
    #1;
    chk("strobed read", l_dq_o, MEM1);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    chk("reset oe", {14'h0, l_dq_oe, r_dq_oe}, 18'h0);
    t_basic();
    t_lanes();
    t_pipe();
    t_burst();
    t_desel();
    t_gate();
    end_of_test();
  end

  // Roughly 58 cycles including reset; about fourteen times that before giving up
  initial begin
    #8000;
    n_fail++;
    end_of_test();
  end
endmodule
